// File: src/integer_load_agen_extend.sv
// Contract
// RULE1: displacement is sign-extended and added to base
// RULE2: base field zero adds zero in displacement
// RULE3: indexed address is base plus index
// RULE4: indexed with base field zero uses zero
// RULE5: indirect uses base, zero when field zero
// RULE6: valid update writes address to base register
// RULE7: update with base zero or equal dest invalid
// RULE8: update forms always add the base contents
// RULE9: big-endian assembly unless little-endian selected
// RULE10: byte load zero-extends into destination
// RULE11: halfword zero load clears upper bits
// RULE12: algebraic halfword sign-extends from its msb
// RULE13: word zero load clears upper 32 bits
// RULE14: algebraic word sign-extends into upper half
// RULE15: doubleword load fills whole destination
// RULE16: address is 64-bit sum, carry dropped
// RULE17: invalid form flagged, no register written
//
// integer load path: address generation, memory request, extension
// assumes decode holds operands only for the issue cycle, littleEndian until write-back, and memory
// answers with a one-cycle memValid pulse some cycles after memReq
`timescale 1ns/1ps
module integer_load_agen_extend (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rst,
  // issue from decode and register file
  input  wire logic                       issueValid,
  input  wire load_pkg::addr_mode_t       issueMode,
  input  wire logic                       issueUpdate,
  input  wire load_pkg::load_size_t       issueSize,
  input  wire logic                       issueSigned,
  input  wire logic                       littleEndian,
  input  wire logic [4:0]                 baseRegField,
  input  wire logic [4:0]                 destRegField,
  input  wire logic [63:0]                baseVal,
  input  wire logic [63:0]                indexVal,
  input  wire logic [15:0]                disp,
  output logic                            issueReady,
  // data memory
  output logic                            memReq,
  output logic [63:0]                     memAddr,
  output load_pkg::load_size_t            memSize,
  input  wire logic                       memValid,
  input  wire logic [63:0]                memData,
  // register write-back
  output logic                            destWe,
  output logic [4:0]                      destIdx,
  output logic [63:0]                     destData,
  output logic                            baseWe,
  output logic [4:0]                      baseIdx,
  output logic [63:0]                     baseData,
  // exception logic
  output logic                            invalidForm
);
  import load_pkg::*;

  load_if lif ();

  load_state_t             state_reg, state_next;
  load_size_t              size_reg;
  logic                    signed_reg;
  logic                    update_reg;
  logic [REG_IDX_W-1:0]    dest_reg;
  logic [REG_IDX_W-1:0]    base_reg;
  logic [XLEN-1:0]         ea_reg;

  // operands go straight to the address adder in the issue cycle
  assign lif.mode         = issueMode;
  assign lif.update       = issueUpdate;
  assign lif.baseRegField = baseRegField;
  assign lif.baseVal      = baseVal;
  assign lif.indexVal     = indexVal;
  assign lif.disp         = disp;
  assign lif.size         = size_reg;
  assign lif.signedLoad   = signed_reg;
  assign lif.littleEndian = littleEndian;
  assign lif.memData      = memData;

  load_agen   u_agen (.lif(lif));
  load_extend u_ext  (.lif(lif));

  wire idle      = (state_reg == ST_IDLE);
  wire accept    = idle && issueValid;
  // update form with base zero or base equal to destination is invalid
  wire badUpdate = issueUpdate &&
                   ((baseRegField == GPR_ZERO) ||
                    (baseRegField == destRegField)); // RULE7
  wire start     = accept && !badUpdate;
  // signed loads only exist for halfword and word sizes
  wire sgnOk     = issueSigned &&
                   ((issueSize == SIZE_HALF) || (issueSize == SIZE_WORD));

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (memValid) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // captured instruction context
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      size_reg   <= SIZE_BYTE;
      signed_reg <= 1'b0;
      update_reg <= 1'b0;
      dest_reg   <= '0;
      base_reg   <= '0;
      ea_reg     <= '0;
    end else if (start) begin
      size_reg   <= issueSize;
      signed_reg <= sgnOk;
      update_reg <= issueUpdate;
      dest_reg   <= destRegField;
      base_reg   <= baseRegField;
      ea_reg     <= lif.effectiveAddr; // RULE16
    end
  end

  // memory request: one-cycle pulse right after start (accepted issue that is not an invalid update form)
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      memReq  <= 1'b0;
      memAddr <= '0;
      memSize <= SIZE_BYTE;
    end else begin
      memReq <= start;
      if (start) begin
        memAddr <= lif.effectiveAddr; // RULE1 RULE3 RULE5
        memSize <= issueSize;
      end
    end
  end

  // ready only while idle, registered from state_next so it rises on the same edge that returns the state to idle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      issueReady <= 1'b0;
    end else begin
      issueReady <= (state_next == ST_IDLE);
    end
  end

  // invalid form: pulse to exception logic, no write-back started
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      invalidForm <= 1'b0;
    end else begin
      invalidForm <= accept && badUpdate; // RULE17
    end
  end

  // write-back on memory answer: destination always, base on update
  wire wbFire = (state_reg == ST_WAIT) && memValid;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      destWe   <= 1'b0;
      destIdx  <= '0;
      destData <= '0;
      baseWe   <= 1'b0;
      baseIdx  <= '0;
      baseData <= '0;
    end else begin
      destWe <= wbFire; // RULE6
      baseWe <= wbFire && update_reg; // RULE6
      if (wbFire) begin
        destIdx  <= dest_reg;
        destData <= lif.extended; // RULE9 RULE10 RULE12 RULE15
        baseIdx  <= base_reg;
        baseData <= ea_reg; // RULE6
      end
    end
  end
endmodule // integer_load_agen_extend

// File: src/load_agen.sv
// effective address generator for integer loads
// assumes operands are stable in the cycle they are sampled
`timescale 1ns/1ps
module load_agen (
  load_if.agen lif
);
  import load_pkg::*;
  wire             baseIsZero = (lif.baseRegField == GPR_ZERO);
  // update forms always add the base register, never zero
  wire             useZero    = baseIsZero && !lif.update; // RULE8
  wire [XLEN-1:0]  baseTerm   = useZero ? '0 : lif.baseVal; // RULE2 RULE4
  wire [XLEN-1:0]  dispExt    =
    {{(XLEN-DISP_W){lif.disp[DISP_W-1]}}, lif.disp}; // RULE1
  // scaled form: low two bits of the field are cleared
  wire [XLEN-1:0]  dsExt      = {dispExt[XLEN-1:2], 2'b00};
  wire [XLEN-1:0]  offset     =
    (lif.mode == MODE_DISP)    ? dispExt :
    (lif.mode == MODE_DSCALED) ? dsExt :
    (lif.mode == MODE_INDEXED) ? lif.indexVal : '0; // RULE3 RULE5
  // carry out of bit 63 is dropped by the width of the sum
  assign lif.effectiveAddr = baseTerm + offset; // RULE16
endmodule // load_agen

// File: src/load_extend.sv
// loaded-element extractor and zero/sign extender
// assumes the element sits right-justified in memData in memory order
`timescale 1ns/1ps
module load_extend (
  load_if.ext lif
);
  import load_pkg::*;
  logic [XLEN-1:0] swapped;
  // default big-endian: element arrives msb-first; little-endian reverses
  always_comb begin
    swapped = lif.memData;
    if (lif.littleEndian) begin // RULE9
      case (lif.size)
        SIZE_HALF:  swapped = {48'h0, lif.memData[7:0], lif.memData[15:8]};
        SIZE_WORD:  swapped = {32'h0, lif.memData[7:0], lif.memData[15:8],
                               lif.memData[23:16], lif.memData[31:24]};
        SIZE_DWORD: begin
          for (int i = 0; i < 8; i++) begin
            swapped[i*8 +: 8] = lif.memData[(7-i)*8 +: 8];
          end
        end
        default:    swapped = lif.memData;
      endcase
    end
  end
  wire [BYTE_W-1:0] b = swapped[BYTE_W-1:0];
  wire [HALF_W-1:0] h = swapped[HALF_W-1:0];
  wire [WORD_W-1:0] w = swapped[WORD_W-1:0];
  wire hFill = lif.signedLoad & h[HALF_W-1];
  wire wFill = lif.signedLoad & w[WORD_W-1];
  assign lif.extended =
    (lif.size == SIZE_BYTE) ? {{(XLEN-BYTE_W){1'b0}}, b} : // RULE10
    (lif.size == SIZE_HALF) ? {{(XLEN-HALF_W){hFill}}, h} : // RULE11 RULE12
    (lif.size == SIZE_WORD) ? {{(XLEN-WORD_W){wFill}}, w} : // RULE13 RULE14
    swapped; // RULE15
endmodule // load_extend

// File: src/load_if.sv
// interface between the load sequencer and its helpers
// assumes one clock; all signals combinational between modules
`timescale 1ns/1ps
interface load_if;
  import load_pkg::*;
  addr_mode_t             mode;
  logic                   update;
  logic [REG_IDX_W-1:0]   baseRegField;
  logic [XLEN-1:0]        baseVal;
  logic [XLEN-1:0]        indexVal;
  logic [DISP_W-1:0]      disp;
  logic [XLEN-1:0]        effectiveAddr;
  load_size_t             size;
  logic                   signedLoad;
  logic                   littleEndian;
  logic [XLEN-1:0]        memData;
  logic [XLEN-1:0]        extended;
  modport seq  (output mode, update, baseRegField, baseVal, indexVal, disp,
                size, signedLoad, littleEndian, memData,
                input effectiveAddr, extended);
  modport agen (input mode, update, baseRegField, baseVal, indexVal, disp,
                output effectiveAddr);
  modport ext  (input size, signedLoad, littleEndian, memData,
                output extended);
endinterface

// File: src/load_pkg.sv
// load path package: modes, sizes, widths and state encodings
// assumes a 64-bit core with 32 general-purpose registers
package load_pkg;
  localparam int XLEN      = 64;
  localparam int REG_IDX_W = 5;
  localparam int DISP_W    = 16;
  localparam int HALF_W    = 16;
  localparam int BYTE_W    = 8;
  localparam int WORD_W    = 32;
  localparam logic [REG_IDX_W-1:0] GPR_ZERO = 5'h00;

  typedef enum logic [1:0] {
    MODE_DISP     = 2'h0,
    MODE_INDEXED  = 2'h1,
    MODE_INDIRECT = 2'h2,
    MODE_DSCALED  = 2'h3
  } addr_mode_t;

  typedef enum logic [1:0] {
    SIZE_BYTE  = 2'h0,
    SIZE_HALF  = 2'h1,
    SIZE_WORD  = 2'h2,
    SIZE_DWORD = 2'h3
  } load_size_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_WAIT = 3'h2,
    ST_DONE = 3'h4
  } load_state_t;
endpackage

// File: tb/integer_load_agen_extend_bench.sv
// self-checking bench for the integer load path
// assumes the memory stand-in and the bound checker are compiled first
`timescale 1ns/1ps
module integer_load_agen_extend_bench;
  import load_pkg::*;
  typedef struct {
    logic        inv, upd;
    logic [4:0]  d, f;
    load_size_t  z;
    logic [63:0] ea, dat;
  } exp_t;
  exp_t q[$];
  exp_t e;
  logic mclk = 1'b0;
  logic rst, issueValid, issueUpdate, issueSigned, littleEndian, memValid;
  logic issueReady, memReq, destWe, baseWe, invalidForm;
  addr_mode_t issueMode;
  load_size_t issueSize, memSize;
  logic [4:0] baseRegField, destRegField, destIdx, baseIdx;
  logic [15:0] disp;
  logic [63:0] baseVal, indexVal, memAddr, memData, destData, baseData;
  logic [2:0] lag;
  int nErrors = 0, samplesChecked = 0;
  always #10 mclk = ~mclk;
  integer_load_agen_extend u_integer_load_agen_extend (.mclk, .rst,
    .issueValid, .issueMode, .issueUpdate, .issueSize, .issueSigned,
    .littleEndian, .baseRegField, .destRegField, .baseVal, .indexVal,
    .disp, .issueReady, .memReq, .memAddr, .memSize, .memValid, .memData,
    .destWe, .destIdx, .destData, .baseWe, .baseIdx, .baseData,
    .invalidForm);
  load_mem_model u_load_mem_model (.mclk, .rst, .memReq, .memAddr, .lag,
    .memValid, .memData);
  function automatic logic [63:0] eaOf(addr_mode_t m, logic u,
      logic [4:0] f, logic [63:0] b, x, logic [15:0] s);
    logic [63:0] bs, sx;
    bs = (f == 5'h00 && !u) ? 64'h0 : b;
    sx = {{48{s[15]}}, s};
    case (m)
      MODE_DISP: eaOf = bs + sx;
      MODE_INDEXED: eaOf = bs + x;
      MODE_INDIRECT: eaOf = bs;
      default: eaOf = bs + {sx[63:2], 2'h0};
    endcase
  endfunction
  function automatic logic [63:0] extOf(logic [63:0] a, load_size_t z,
      logic g, logic l);
    logic [63:0] m, r;
    int n;
    m = {a[31:0] ^ 32'h5A3C96E1, ~a[63:32]};
    n = 1 << z;
    r = m;
    if (l) for (int k = 0; k < n; k++) r[8*k +: 8] = m[8*(n-1-k) +: 8];
    case (z)
      SIZE_BYTE: extOf = {56'h0, r[7:0]};
      SIZE_HALF: extOf = {{48{g & r[15]}}, r[15:0]};
      SIZE_WORD: extOf = {{32{g & r[31]}}, r[31:0]};
      default: extOf = r;
    endcase
  endfunction
  task automatic cmpWord(logic [63:0] got, exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // flags, register numbers and sizes
  task automatic cmpField(logic [7:0] got, exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %0t: field %h expected %h", $time, got, exp);
    end
  endtask
  task automatic issue(addr_mode_t m, logic u, load_size_t z, logic g, l,
      logic [4:0] f, dr);
    exp_t x;
    logic [63:0] b, i;
    logic [15:0] s;
    b = {$urandom, $urandom};
    i = {$urandom, $urandom};
    s = 16'($urandom);
    @(posedge mclk);
    while (issueReady !== 1'b1) @(posedge mclk);
    {issueValid, issueUpdate} <= {1'b1, u};
    issueMode <= m;
    issueSize <= z;
    {issueSigned, littleEndian, baseRegField, destRegField} <= {g, l, f, dr};
    {baseVal, indexVal, disp} <= {b, i, s};
    lag <= 3'($urandom_range(0, 4));
    x.inv = u && (f == 5'h00 || f == dr);
    x.upd = u;
    x.d = dr;
    x.f = f;
    x.z = z;
    x.ea = eaOf(m, u, f, b, i, s);
    x.dat = extOf(x.ea, z, g, l);
    q.push_back(x);
    @(posedge mclk);
    issueValid <= 1'b0;
  endtask
  always @(posedge mclk) if (rst === 1'b0) begin
    if (memReq === 1'b1) begin
      cmpWord(memAddr, q[0].ea);
      cmpField(8'(q[0].inv), 8'h00);
      cmpField(8'(memSize), 8'(q[0].z));
    end
    if (invalidForm === 1'b1) begin
      e = q.pop_front();
      cmpField(8'(e.inv), 8'h01);
    end
    if (destWe === 1'b1) begin
      e = q.pop_front();
      cmpField(8'(e.inv), 8'h00);
      cmpWord(destData, e.dat);
      cmpField(8'(destIdx), 8'(e.d));
      cmpField(8'(baseWe), 8'(e.upd));
      if (e.upd) cmpWord(baseData, e.ea);
      if (e.upd) cmpField(8'(baseIdx), 8'(e.f));
    end
  end
  task automatic stopTest;
    $display("checked %0d errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    // the loads need well under half of this span
    #100000;
    $display("ERROR %0t: watchdog expired", $time);
    nErrors++;
    stopTest;
  end
  initial begin
    void'($urandom(32'h7711C48F));
    {rst, issueValid, issueUpdate, issueSigned, littleEndian} = 5'h10;
    issueMode = MODE_DISP;
    issueSize = SIZE_BYTE;
    {baseRegField, destRegField, lag} = '0;
    {baseVal, indexVal, disp} = '0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    // every mode, size, sign and byte order, base field zero now and then
    for (int i = 0; i < 128; i++)
      issue(addr_mode_t'(i % 4), 1'b0, load_size_t'(i / 4 % 4), i[4], i[5],
            (i % 5 == 0) ? 5'h00 : 5'($urandom_range(1, 31)), 5'($urandom));
    // zero base and base equal to destination, back to back
    for (int i = 0; i < 4; i++)
      issue(MODE_INDEXED, 1'b1, SIZE_WORD, 1'b0, 1'b0, i[0] ? 5'h07 : 5'h00,
            5'h07);
    for (int i = 0; i < 32; i++)
      issue(addr_mode_t'(i % 2), 1'b1, load_size_t'(i % 4), i[2], i[3],
            5'($urandom_range(1, 15)), 5'($urandom_range(16, 31)));
    repeat (20) @(posedge mclk);
    if (q.size() != 0) begin
      nErrors++;
      $display("ERROR %0t: results missing", $time);
    end
    stopTest;
  end
endmodule // integer_load_agen_extend_bench

// File: tb/load_mem_model.sv
// data memory stand-in: answers each request after a chosen lag
// assumes one request outstanding and memAddr held while waiting
`timescale 1ns/1ps
module load_mem_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        memReq,
  input  wire logic [63:0] memAddr,
  input  wire logic [2:0]  lag,
  output logic             memValid,
  output logic [63:0]      memData
);
  logic [2:0] cnt;
  logic       busy;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      cnt <= 3'h0;
      memValid <= 1'b0;
      memData <= 64'h0;
    end else begin
      memValid <= 1'b0;
      // stale outside the answer cycle, so a late sample cannot match
      memData <= ~memData;
      if (memReq) begin
        busy <= 1'b1;
        cnt <= lag;
      end else if (busy && cnt == 3'h0) begin
        busy <= 1'b0;
        memValid <= 1'b1;
        memData <= {memAddr[31:0] ^ 32'h5A3C96E1, ~memAddr[63:32]};
      end else if (busy) cnt <= cnt - 3'h1;
    end
  end
endmodule // load_mem_model

// File: tb/load_path_asserts.sv
// timing and address checks on the integer load path ports
// assumes it is bound to the top module of the load path
`timescale 1ns/1ps
module load_path_asserts
  import load_pkg::*;
(
  // handshake and pulses
  input wire logic        mclk, rst, issueValid, issueReady, issueUpdate,
  input wire logic        memReq, memValid, destWe, baseWe, invalidForm,
  // operands and results
  input wire addr_mode_t  issueMode,
  input wire load_size_t  memSize,
  input wire logic [4:0]  baseRegField, destRegField,
  input wire logic [15:0] disp,
  input wire logic [63:0] baseVal, indexVal, memAddr, destData, baseData
);
  logic waitReg;
  wire take = issueValid && issueReady;
  wire bad = issueUpdate &&
             (baseRegField == 5'h00 || baseRegField == destRegField);
  // update forms never substitute zero for the base
  wire [63:0] baseSel = (baseRegField == 5'h00 && !issueUpdate) ?
                        64'h0 : baseVal;
  wire [63:0] dispExt = {{48{disp[15]}}, disp};
  always_ff @(posedge mclk or posedge rst)
    if (rst) waitReg <= 1'b0;
    else waitReg <= memReq | (waitReg & ~memValid);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_req_follows: assert property (take && !bad |=> memReq && !issueReady)
    else $error("no memory request after a valid issue");
  a_inval_pulse: assert property (take && bad |=> invalidForm && !memReq)
    else $error("invalid form not flagged");
  a_inval_quiet: assert property (invalidForm |-> !destWe && !baseWe)
    else $error("register written on invalid form");
  a_disp_sum: assert property (take && !bad && issueMode == MODE_DISP
    |=> memAddr == $past(baseSel) + $past(dispExt))
    else $error("displacement address wrong");
  a_disp_zero: assert property (take && issueMode == MODE_DISP &&
    !issueUpdate && baseRegField == 5'h00 |=> memAddr == $past(dispExt))
    else $error("zero base not substituted");
  a_index_sum: assert property (take && !bad && issueMode == MODE_INDEXED
    |=> memAddr == $past(baseSel) + $past(indexVal))
    else $error("indexed address wrong");
  a_ind_addr: assert property (take && !bad && issueMode == MODE_INDIRECT
    |=> memAddr == $past(baseSel))
    else $error("indirect address wrong");
  a_update_ea: assert property (baseWe |-> destWe && baseData == memAddr)
    else $error("base write-back is not the address");
  a_wb_timing: assert property (waitReg && memValid |=> destWe ##1 !destWe)
    else $error("write-back pulse misplaced");
  a_byte_zero: assert property (destWe && memSize == SIZE_BYTE
    |-> destData[63:8] == 56'h0)
    else $error("byte load not zero-extended");
  c_inval: cover property (invalidForm);
  c_update: cover property (baseWe);
  c_dword: cover property (destWe && memSize == SIZE_DWORD);
endmodule // load_path_asserts
bind integer_load_agen_extend load_path_asserts u_load_path_asserts (
  .mclk, .rst, .issueValid, .issueReady, .issueUpdate, .memReq, .memValid,
  .destWe, .baseWe, .invalidForm, .issueMode, .memSize, .baseRegField,
  .destRegField, .disp, .baseVal, .indexVal, .memAddr, .destData, .baseData);
